// *** agm_addr_gen.sv ***
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
// Function
// - Dual-operand pointers 8,9 feed X read path; 10,11 feed Y path.
// - Dual-operand modes: indirect, post-modify by 2, 4, 6, indexed.
// - Move source and destination share one 16-bit offset register field.
// - One circular buffer in X space, one in Y space.
// - All buffers check both bounds, power-of-two length or not.
// - Bounds come from 16-bit start and end registers, max 32K words.
// - Y circular addresses keep least significant bit clear.
// - X circular active when X select not 15 and bit 15 set.
// - Y circular active when Y select not 15 and bit 14 set.
// - Bounds test beyond, not just equal, so overshoot still wraps.
// - Write back only in pre/post-modify; offset modes keep pointer.
// - Bit reversal only on X write generator.
// - Only the modifier is bit-reversed; pointers stay normal order.
// - Reversal needs select not 15, enable set, pre/post increment.
// - Pivot holds words; hardware scales it to bytes.
// - Non-word or other-mode accesses get normal addresses.
// - Reversal steps by pivot, ignores mode offset, clears bit 0.
// - Reversal beats circular on X write; X read stays circular.
module agm_addr_gen #(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoder requests
  input wire agm_pkg::agm_req_t xrd_req,
  input wire agm_pkg::agm_req_t xwr_req,
  input wire agm_pkg::agm_req_t yrd_req,
  input wire agm_pkg::agm_dual_t dual_req,
  // Memory address ports and write-back
  output agm_pkg::agm_rsp_t xrd_rsp,
  output agm_pkg::agm_rsp_t xwr_rsp,
  output agm_pkg::agm_rsp_t yrd_rsp
);
  logic [AW-1:0] xstart_ff, xend_ff, ystart_ff, yend_ff, ctrl_ff, pivot_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  agm_pkg::agm_rsp_t xrd_ff, xwr_ff, yrd_ff;
  agm_pkg::agm_rsp_t nxt_xrd, nxt_xwr, nxt_yrd;

  // Control decode
  wire [3:0] xsel = ctrl_ff[agm_pkg::XSEL_LO +: 4];
  wire [3:0] ysel = ctrl_ff[agm_pkg::YSEL_LO +: 4];
  wire [3:0] rsel = ctrl_ff[agm_pkg::RSEL_LO +: 4];
  wire x_circ_on = (xsel != agm_pkg::SEL_NONE) &&
                   ctrl_ff[agm_pkg::XEN_BIT];
  wire y_circ_on = (ysel != agm_pkg::SEL_NONE) &&
                   ctrl_ff[agm_pkg::YEN_BIT];
  wire rev_on = (rsel != agm_pkg::SEL_NONE) &&
                pivot_ff[agm_pkg::REN_BIT];
  wire [14:0] pivot = pivot_ff[14:0];

  // APB decode
  wire setup = psel && !penable;
  // Writes commit at the access edge that completes the transfer
  wire wr_hit = psel && penable && pready_ff && pwrite;
  wire rd_hit = setup && !pwrite;
  wire a_xs = paddr == agm_pkg::ADDR_XSTART;
  wire a_xe = paddr == agm_pkg::ADDR_XEND;
  wire a_ys = paddr == agm_pkg::ADDR_YSTART;
  wire a_ye = paddr == agm_pkg::ADDR_YEND;
  wire a_ct = paddr == agm_pkg::ADDR_CTRL;
  wire a_pv = paddr == agm_pkg::ADDR_PIVOT;
  wire a_xp = paddr == agm_pkg::ADDR_XPTR;
  wire mapped = a_xs | a_xe | a_ys | a_ye | a_ct | a_pv | a_xp;
  wire [15:0] rd_mux = a_xs ? xstart_ff : a_xe ? xend_ff :
                       a_ys ? ystart_ff : a_ye ? yend_ff :
                       a_ct ? ctrl_ff : a_pv ? pivot_ff :
                       a_xp ? xwr_ff.wb_val : 16'h0000;

  // Bit-reversed increment: reverse, add, reverse back (carry runs down)
  function automatic logic [14:0] rev15(input logic [14:0] v);
    logic [14:0] r;
    r = '0;
    for (int i = 0; i < 15; i++) r[i] = v[14-i];
    return r;
  endfunction

  function automatic logic [15:0] rev_step(input logic [15:0] p,
                                           input logic [14:0] m);
    logic [14:0] widx;
    widx = rev15(15'(rev15(p[15:1]) + rev15(m)));
    return {widx, 1'b0};
  endfunction

  // Circular correction with beyond-bound tests in both directions
  function automatic logic [15:0] wrap(input logic [15:0] a,
                                       input logic [15:0] s,
                                       input logic [15:0] e,
                                       input logic on);
    logic [16:0] len;
    logic [15:0] r;
    len = 17'(e) - 17'(s) + 17'd1;
    r = a;
    if (on && a > e) begin
      r = 16'(17'(a) - len);
    end else if (on && a < s) begin
      r = 16'(17'(a) + len);
    end
    return r;
  endfunction

  // Normal effective-address step for one request
  function automatic agm_pkg::agm_rsp_t calc(input agm_pkg::agm_req_t q,
                                             input logic [15:0] s,
                                             input logic [15:0] e,
                                             input logic circ,
                                             input logic clr0);
    agm_pkg::agm_rsp_t r;
    logic [15:0] step, ea, nv;
    logic upd;
    r = '0;
    step = q.word ? agm_pkg::WORD_STEP : 16'h0001;
    ea = q.base;
    nv = q.base;
    upd = 1'b0;
    case (q.mode)
      agm_pkg::AGM_POSTINC: begin
        nv = wrap(q.base + step, s, e, circ);
        upd = 1'b1;
      end
      agm_pkg::AGM_POSTDEC: begin
        nv = wrap(q.base - step, s, e, circ);
        upd = 1'b1;
      end
      agm_pkg::AGM_PREINC: begin
        ea = wrap(q.base + step, s, e, circ);
        nv = ea;
        upd = 1'b1;
      end
      agm_pkg::AGM_PREDEC: begin
        ea = wrap(q.base - step, s, e, circ);
        nv = ea;
        upd = 1'b1;
      end
      // Same offset field for source and destination of a move
      agm_pkg::AGM_REGOFS, agm_pkg::AGM_LITOFS: begin
        ea = wrap(q.base + q.ofs, s, e, circ);
      end
      default: begin
        ea = q.base;
      end
    endcase
    if (clr0) begin
      ea[0] = 1'b0;
      nv[0] = 1'b0;
    end
    r.valid = q.valid;
    r.addr = ea;
    r.wb_en = q.valid && upd;
    r.wb_ptr = q.ptr;
    r.wb_val = nv;
    return r;
  endfunction

  wire xr_circ = x_circ_on && (xrd_req.ptr == xsel);
  wire y_circ = y_circ_on && (yrd_req.ptr == ysel);
  wire xw_inc = (xwr_req.mode == agm_pkg::AGM_PREINC) ||
                (xwr_req.mode == agm_pkg::AGM_POSTINC);
  wire xw_rev = rev_on && (xwr_req.ptr == rsel) && xw_inc &&
                xwr_req.word;
  wire xw_circ = x_circ_on && (xwr_req.ptr == xsel) &&
                 !xw_rev;

  // Dual-operand fetch path, X side pointers 8/9, Y side 10/11
  wire [3:0] dx_ptr = dual_req.xsel ? agm_pkg::PTR_X1 : agm_pkg::PTR_X0;
  wire [3:0] dy_ptr = dual_req.ysel ? agm_pkg::PTR_Y1 : agm_pkg::PTR_Y0;
  wire [15:0] dx_stp = {13'h0000, dual_req.xstep, 1'b0};
  wire [15:0] dy_stp = {13'h0000, dual_req.ystep, 1'b0};
  wire dx_circ = x_circ_on && (dx_ptr == xsel);
  wire dy_circ = y_circ_on && (dy_ptr == ysel);

  always_comb begin
    nxt_xrd = calc(xrd_req, xstart_ff, xend_ff, xr_circ, 1'b0);
    nxt_yrd = calc(yrd_req, ystart_ff, yend_ff, y_circ, 1'b1);
    nxt_xwr = calc(xwr_req, xstart_ff, xend_ff, xw_circ, 1'b0);
    if (xw_rev) begin
      nxt_xwr.wb_val = rev_step(xwr_req.base, pivot);
      nxt_xwr.addr = (xwr_req.mode == agm_pkg::AGM_PREINC) ?
                     nxt_xwr.wb_val : {xwr_req.base[15:1], 1'b0};
    end
    if (dual_req.valid) begin
      nxt_xrd.valid = 1'b1;
      nxt_xrd.wb_ptr = dx_ptr;
      nxt_xrd.addr = dual_req.xidx ?
        wrap(dual_req.xbase + dual_req.xofs, xstart_ff, xend_ff, dx_circ) :
        dual_req.xbase;
      nxt_xrd.wb_en = !dual_req.xidx && (dual_req.xstep != 2'b00);
      nxt_xrd.wb_val = dual_req.xdir ?
        wrap(dual_req.xbase - dx_stp, xstart_ff, xend_ff, dx_circ) :
        wrap(dual_req.xbase + dx_stp, xstart_ff, xend_ff, dx_circ);
      nxt_yrd.valid = 1'b1;
      nxt_yrd.wb_ptr = dy_ptr;
      nxt_yrd.addr = dual_req.yidx ?
        wrap(dual_req.ybase + dual_req.yofs, ystart_ff, yend_ff, dy_circ) :
        dual_req.ybase;
      nxt_yrd.addr[0] = 1'b0;
      nxt_yrd.wb_en = !dual_req.yidx && (dual_req.ystep != 2'b00);
      nxt_yrd.wb_val = dual_req.ydir ?
        wrap(dual_req.ybase - dy_stp, ystart_ff, yend_ff, dy_circ) :
        wrap(dual_req.ybase + dy_stp, ystart_ff, yend_ff, dy_circ);
      nxt_yrd.wb_val[0] = 1'b0;
    end
  end

  // Address results, registered once per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xrd_ff <= '0;
      xwr_ff <= '0;
      yrd_ff <= '0;
    end else if (clk_en) begin
      xrd_ff <= nxt_xrd;
      xwr_ff <= nxt_xwr;
      yrd_ff <= nxt_yrd;
    end
  end

  // Register file, zero-wait APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xstart_ff <= agm_pkg::RST_VAL;
      xend_ff <= agm_pkg::RST_END;
      ystart_ff <= agm_pkg::RST_VAL;
      yend_ff <= agm_pkg::RST_END;
      ctrl_ff <= agm_pkg::RST_CTRL;
      pivot_ff <= agm_pkg::RST_VAL;
    end else if (clk_en && wr_hit) begin
      if (a_xs) xstart_ff <= pwdata[15:0];
      if (a_xe) xend_ff <= pwdata[15:0];
      if (a_ys) ystart_ff <= {pwdata[15:1], 1'b0};
      if (a_ye) yend_ff <= {pwdata[15:1], 1'b1};
      if (a_ct) ctrl_ff <= pwdata[15:0];
      if (a_pv) pivot_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      prdata_ff <= rd_hit ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign xrd_rsp = xrd_ff;
  assign xwr_rsp = xwr_ff;
  assign yrd_rsp = yrd_ff;

  sequence s_rev_req;
    clk_en && xw_rev && xwr_req.valid;
  endsequence

  a_rev_lsb_clr: assert property (@(posedge pclk) disable iff (!presetn)
    s_rev_req |=> xwr_rsp.wb_val[0] == 1'b0)
    else $error("reversed pointer bit 0 set");
  a_y_lsb_clr: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && y_circ && yrd_req.valid |=> yrd_rsp.addr[0] == 1'b0)
    else $error("Y circular address odd");
  a_ofs_no_wb: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !dual_req.valid && xrd_req.mode == agm_pkg::AGM_REGOFS
    |=> !xrd_rsp.wb_en)
    else $error("offset mode wrote back");
  a_x_wrap_hi: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && xr_circ && !dual_req.valid && xrd_req.valid &&
    xrd_req.mode == agm_pkg::AGM_PREINC && xend_ff >= xstart_ff
    |=> xrd_rsp.addr <= $past(xend_ff))
    else $error("X pre-increment not wrapped");
  a_circ_off: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !x_circ_on && !dual_req.valid &&
    xrd_req.mode == agm_pkg::AGM_PREINC && xrd_req.word
    |=> xrd_rsp.addr == $past(xrd_req.base) + agm_pkg::WORD_STEP)
    else $error("X circular active while off");
  a_y_enable: assert property (@(posedge pclk) disable iff (!presetn)
    y_circ |-> ctrl_ff[agm_pkg::YEN_BIT] && ysel != agm_pkg::SEL_NONE)
    else $error("Y circular without enable");
  a_rev_prio: assert property (@(posedge pclk) disable iff (!presetn)
    xw_rev |-> !xw_circ)
    else $error("circular active with reversal");
  a_dual_route: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && dual_req.valid |=> xrd_rsp.wb_ptr[3:1] == 3'b100 &&
    yrd_rsp.wb_ptr[3:1] == 3'b101)
    else $error("dual operand misrouted");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup |=> pready)
    else $error("APB answer late");
endmodule

// *** agm_addr_gen_test.sv ***
`timescale 1ns/1ps
module agm_addr_gen_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  agm_pkg::agm_req_t xrd_req, xwr_req, yrd_req;
  agm_pkg::agm_dual_t dual_req;
  agm_pkg::agm_rsp_t xrd_rsp, xwr_rsp, yrd_rsp;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #25 pclk = ~pclk;

  agm_addr_gen u_agm_addr_gen (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xrd_req(xrd_req), .xwr_req(xwr_req),
    .yrd_req(yrd_req), .dual_req(dual_req), .xrd_rsp(xrd_rsp),
    .xwr_rsp(xwr_rsp), .yrd_rsp(yrd_rsp));

  agm_dec_model u_agm_dec_model (.pclk(pclk), .xrd_req(xrd_req),
    .xwr_req(xwr_req), .yrd_req(yrd_req), .dual_req(dual_req));

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      final_report;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {16'h0000, d}, r, e);
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input agm_pkg::agm_rsp_t g, input logic [15:0] ea,
                         input logic wb, input logic [3:0] p,
                         input logic [15:0] v);
    tests_run++;
    if (g.valid !== 1'b1 || g.addr !== ea || g.wb_en !== wb ||
        (wb && (g.wb_ptr !== p || g.wb_val !== v))) begin
      num_errors++;
      $display("MISMATCH %0t addr %h wb %h expected %h %h", $time,
               g.addr, g.wb_val, ea, v);
    end
  endtask

  function automatic agm_pkg::agm_req_t mk(input logic [3:0] p,
      input agm_pkg::agm_mode_t m, input logic [15:0] b,
      input logic [15:0] o, input logic w);
    mk = '{valid: 1'b1, ptr: p, mode: m, base: b, ofs: o, word: w};
  endfunction

  task automatic xr1(input logic [3:0] p, input agm_pkg::agm_mode_t m,
                     input logic [15:0] b, input logic [15:0] o,
                     input logic [15:0] ea, input logic wb,
                     input logic [15:0] v);
    u_agm_dec_model.send(mk(p, m, b, o, 1'b1), '0, '0, '0);
    chk_rsp(xrd_rsp, ea, wb, p, v);
  endtask

  task automatic xw1(input agm_pkg::agm_mode_t m, input logic [15:0] b,
                     input logic w, input logic [15:0] ea,
                     input logic [15:0] v);
    u_agm_dec_model.send('0, mk(4'h4, m, b, 16'h0000, w), '0, '0);
    chk_rsp(xwr_rsp, ea, 1'b1, 4'h4, v);
  endtask

  task automatic t_regs;
    logic [7:0] a [6] = '{agm_pkg::ADDR_XSTART, agm_pkg::ADDR_XEND,
      agm_pkg::ADDR_YSTART, agm_pkg::ADDR_YEND, agm_pkg::ADDR_CTRL,
      agm_pkg::ADDR_PIVOT};
    logic [15:0] v [6] = '{agm_pkg::RST_VAL, agm_pkg::RST_END,
      agm_pkg::RST_VAL, agm_pkg::RST_END, agm_pkg::RST_CTRL,
      agm_pkg::RST_VAL};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0, r, e);
      chk_val(r, {16'h0000, v[i]});
    end
    wr(agm_pkg::ADDR_XEND, 16'hffff);
    apb(1'b0, agm_pkg::ADDR_XEND, 32'h0, r, e);
    chk_val(r, 32'h0000ffff);
    wr(agm_pkg::ADDR_YSTART, 16'h1001);
    apb(1'b0, agm_pkg::ADDR_YSTART, 32'h0, r, e);
    chk_val(r, 32'h00001000);
    wr(agm_pkg::ADDR_YEND, 16'h2006);
    apb(1'b0, agm_pkg::ADDR_YEND, 32'h0, r, e);
    chk_val(r, 32'h00002007);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk_val({r[31:1], e}, 32'h00000001);
    $display("test regs done");
  endtask

  task automatic t_xcirc;
    wr(agm_pkg::ADDR_XSTART, 16'h1000);
    wr(agm_pkg::ADDR_XEND, 16'h100f);
    wr(agm_pkg::ADDR_CTRL, 16'h8ff2);
    xr1(4'h2, agm_pkg::AGM_POSTINC, 16'h100e, 16'h0, 16'h100e, 1'b1,
        16'h1000);
    xr1(4'h2, agm_pkg::AGM_PREINC, 16'h100e, 16'h0, 16'h1000, 1'b1,
        16'h1000);
    xr1(4'h2, agm_pkg::AGM_REGOFS, 16'h100e, 16'h4, 16'h1002, 1'b0,
        16'h0);
    xr1(4'h3, agm_pkg::AGM_POSTINC, 16'h100e, 16'h0, 16'h100e, 1'b1,
        16'h1010);
    wr(agm_pkg::ADDR_CTRL, 16'h0ff2);
    xr1(4'h2, agm_pkg::AGM_PREINC, 16'h100e, 16'h0, 16'h1010, 1'b1,
        16'h1010);
    xr1(4'h2, agm_pkg::AGM_POSTINC, 16'h100e, 16'h0, 16'h100e, 1'b1,
        16'h1010);
    $display("test x circular done");
  endtask

  task automatic t_dual;
    agm_pkg::agm_dual_t d;
    wr(agm_pkg::ADDR_YSTART, 16'h2000);
    wr(agm_pkg::ADDR_YEND, 16'h2007);
    wr(agm_pkg::ADDR_CTRL, 16'h4faf);
    u_agm_dec_model.send('0, '0, mk(4'ha, agm_pkg::AGM_POSTINC, 16'h2005,
      16'h0, 1'b1), '0);
    chk_rsp(yrd_rsp, 16'h2004, 1'b1, 4'ha, 16'h2006);
    d = '0;
    d.valid = 1'b1;
    d.xbase = 16'h0100;
    d.ybase = 16'h2006;
    d.xstep = 2'd3;
    d.ystep = 2'd1;
    u_agm_dec_model.send('0, '0, '0, d);
    chk_rsp(xrd_rsp, 16'h0100, 1'b1, 4'h8, 16'h0106);
    chk_rsp(yrd_rsp, 16'h2006, 1'b1, 4'ha, 16'h2000);
    d.xsel = 1'b1;
    d.ysel = 1'b1;
    d.xidx = 1'b1;
    d.xofs = 16'h0004;
    d.xbase = 16'h0200;
    d.ybase = 16'h2000;
    d.ystep = 2'd2;
    d.ydir = 1'b1;
    wr(agm_pkg::ADDR_CTRL, 16'h4fbf);
    u_agm_dec_model.send('0, '0, '0, d);
    chk_rsp(xrd_rsp, 16'h0204, 1'b0, 4'h9, 16'h0);
    chk_rsp(yrd_rsp, 16'h2000, 1'b1, 4'hb, 16'h2004);
    $display("test dual done");
  endtask

  task automatic t_brev;
    wr(agm_pkg::ADDR_XSTART, 16'h1000);
    wr(agm_pkg::ADDR_XEND, 16'h100f);
    wr(agm_pkg::ADDR_CTRL, 16'h84f4);
    wr(agm_pkg::ADDR_PIVOT, 16'h8008);
    u_agm_dec_model.send(mk(4'h4, agm_pkg::AGM_POSTINC, 16'h100e, 16'h0,
      1'b1), mk(4'h4, agm_pkg::AGM_POSTINC, 16'h1000, 16'h0, 1'b1), '0,
      '0);
    chk_rsp(xrd_rsp, 16'h100e, 1'b1, 4'h4, 16'h1000);
    chk_rsp(xwr_rsp, 16'h1000, 1'b1, 4'h4, 16'h1010);
    xw1(agm_pkg::AGM_POSTINC, 16'h1010, 1'b1, 16'h1010, 16'h1008);
    xw1(agm_pkg::AGM_PREINC, 16'h1008, 1'b1, 16'h1018, 16'h1018);
    xw1(agm_pkg::AGM_POSTINC, 16'h1000, 1'b0, 16'h1000, 16'h1001);
    xw1(agm_pkg::AGM_POSTDEC, 16'h1002, 1'b1, 16'h1002, 16'h1000);
    xw1(agm_pkg::AGM_POSTINC, 16'h1011, 1'b1, 16'h1010, 16'h1008);
    wr(agm_pkg::ADDR_PIVOT, 16'h0008);
    xw1(agm_pkg::AGM_POSTINC, 16'h1000, 1'b1, 16'h1000, 16'h1002);
    $display("test bit reverse done");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_xcirc;
    t_dual;
    t_brev;
    final_report;
  end
endmodule

// *** agm_dec_model.sv ***
`timescale 1ns/1ps
module agm_dec_model (
  // Clock
  input wire logic pclk,
  // Decoded address requests
  output agm_pkg::agm_req_t xrd_req,
  output agm_pkg::agm_req_t xwr_req,
  output agm_pkg::agm_req_t yrd_req,
  output agm_pkg::agm_dual_t dual_req
);
  initial begin
    xrd_req = '0;
    xwr_req = '0;
    yrd_req = '0;
    dual_req = '0;
  end

  // One decode slot lasts one edge, then every path returns to idle
  task automatic send(input agm_pkg::agm_req_t xr,
                      input agm_pkg::agm_req_t xw,
                      input agm_pkg::agm_req_t yr,
                      input agm_pkg::agm_dual_t d);
    @(posedge pclk);
    xrd_req <= xr;
    xwr_req <= xw;
    yrd_req <= yr;
    dual_req <= d;
    @(posedge pclk);
    xrd_req <= '0;
    xwr_req <= '0;
    yrd_req <= '0;
    dual_req <= '0;
    #1;
  endtask
endmodule

// *** agm_pkg.sv ***
package agm_pkg;
  // APB byte addresses of the control registers
  localparam logic [7:0] ADDR_XSTART = 8'h00;
  localparam logic [7:0] ADDR_XEND = 8'h04;
  localparam logic [7:0] ADDR_YSTART = 8'h08;
  localparam logic [7:0] ADDR_YEND = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PIVOT = 8'h14;
  localparam logic [7:0] ADDR_XPTR = 8'h18;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [15:0] RST_END = 16'h0001;
  localparam logic [15:0] RST_CTRL = 16'h0fff;
  // Control field positions
  localparam int XSEL_LO = 0;
  localparam int YSEL_LO = 4;
  localparam int RSEL_LO = 8;
  localparam int YEN_BIT = 14;
  localparam int XEN_BIT = 15;
  localparam int REN_BIT = 15;
  localparam logic [3:0] SEL_NONE = 4'hf;
  // Pointer registers that feed the dual-operand operand paths
  localparam logic [3:0] PTR_X0 = 4'h8;
  localparam logic [3:0] PTR_X1 = 4'h9;
  localparam logic [3:0] PTR_Y0 = 4'ha;
  localparam logic [3:0] PTR_Y1 = 4'hb;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [2:0] {
    AGM_IND = 3'b000,
    AGM_POSTINC = 3'b001,
    AGM_POSTDEC = 3'b010,
    AGM_PREINC = 3'b011,
    AGM_PREDEC = 3'b100,
    AGM_REGOFS = 3'b101,
    AGM_LITOFS = 3'b110
  } agm_mode_t;

  // One address request from the decoder
  typedef struct packed {
    logic valid;
    logic [3:0] ptr;
    agm_mode_t mode;
    logic [15:0] base;
    logic [15:0] ofs;
    logic word;
  } agm_req_t;

  // One corrected address and pointer write-back
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic wb_en;
    logic [3:0] wb_ptr;
    logic [15:0] wb_val;
  } agm_rsp_t;

  // Dual-operand fetch: post-modify 0, 2, 4 or 6 or indexed
  typedef struct packed {
    logic valid;
    logic xsel;
    logic ysel;
    logic [15:0] xbase;
    logic [15:0] ybase;
    logic [1:0] xstep;
    logic [1:0] ystep;
    logic xidx;
    logic yidx;
    logic xdir;
    logic ydir;
    logic [15:0] xofs;
    logic [15:0] yofs;
  } agm_dual_t;
endpackage
